// ===== inc/ucp_defines.svh
// Constants shared by both ends of the processor port: offsets, PLL multiplier codes, timing
`ifndef UCP_DEFINES_SVH
`define UCP_DEFINES_SVH

`define UCP_CLK_PERIOD_NS 10
`define UCP_HOST_REG_TOP  8'h10
`define UCP_PERIPH_REG_TOP 8'h40
`define UCP_BASE_ADDR_REG 8'h01
`define UCP_BASE_LEN_REG  8'h02
`define UCP_INT_EN_REG    8'h06
`define UCP_INT_STAT_REG  8'h0d
`define UCP_DMA_CNT_REG   8'h3e
`define UCP_MULT_DIRECT   3'h1
`define UCP_MULT_12M      3'h4
`define UCP_STROBE_NS     80
`define UCP_GAP_NS        60
`define UCP_STROBE_CYC    ((`UCP_STROBE_NS + `UCP_CLK_PERIOD_NS - 1) / `UCP_CLK_PERIOD_NS)
`define UCP_GAP_CYC       ((`UCP_GAP_NS + `UCP_CLK_PERIOD_NS - 1) / `UCP_CLK_PERIOD_NS)

`endif

// ===== inc/ucp_pkg.sv
// Types shared by both ends of the processor port
package ucp_pkg;

    typedef logic [7:0] ucp_byte_t;

    typedef enum logic [2:0] {
        UCP_CMD_ADDR_WR,
        UCP_CMD_DATA_WR,
        UCP_CMD_DATA_RD,
        UCP_CMD_DMA_WR,
        UCP_CMD_DMA_RD
    } ucp_cmd_e;

    typedef enum logic [1:0] {
        UCP_ST_IDLE,
        UCP_ST_STROBE,
        UCP_ST_GAP
    } ucp_host_state_e;

endpackage : ucp_pkg

// ===== inc/ucp_if.sv
// Pin-level processor port joining the bus master and the controller
`timescale 1ns/10ps
interface ucp_if;
    import ucp_pkg::*;

    logic      chip_select_n;
    logic      read_strobe_n;
    logic      write_strobe_n;
    logic      addr_select_line;
    logic      dma_ack_n;
    logic      dma_request_n;
    logic      irq_out;
    ucp_byte_t host_data;
    logic      host_data_oe_n;
    ucp_byte_t dev_data;
    logic      dev_data_oe_n;
    ucp_byte_t data_bus;

    // Bus level resolved from the enables; an idle bus floats high
    assign data_bus = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 8'hff);

    modport dev (
        input  chip_select_n, read_strobe_n, write_strobe_n, addr_select_line, dma_ack_n,
        input  data_bus,
        output dma_request_n, irq_out, dev_data, dev_data_oe_n
    );

    modport host (
        output chip_select_n, read_strobe_n, write_strobe_n, addr_select_line, dma_ack_n,
        output host_data, host_data_oe_n,
        input  data_bus, dma_request_n, irq_out
    );
endinterface : ucp_if

// ===== hdl/ucp_dev.sv
// Controller end of the processor port: pointer, 256-byte memory, interrupts, DMA
`timescale 1ns/10ps
`include "ucp_defines.svh"

// Contract
// RULE1: Address write with A low, then data cycle
// RULE2: Cycle ends when strobe or select drops
// RULE3: Eight-bit data, select, two strobes, address line
// RULE4: DMA handshake only in peripheral mode
// RULE5: DMA paced by request, acknowledged with strobe
// RULE6: Block count stops requests when exhausted
// RULE7: One interrupt output from enabled events
// RULE8: Status readable; writing ones clears events
// RULE9: Host mode: 16 register bytes, 240 buffer
// RULE10: Peripheral mode: 64 register bytes, 192 buffer
// RULE11: Data cycles advance the address pointer
// RULE12: Random access rewrites the address each time
// RULE13: Engine data lands at configured base, length
// RULE14: Runs from 12 or 48 MHz reference
// RULE15: Bypass select low bypasses the PLL
// RULE16: Drive data only while select and read; the code also drives on a DMA-acknowledged read without select
module ucp_dev (
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    ucp_if.dev                    bus,
    input  wire logic             periph_mode_i,
    input  wire logic [7:0]       usb_event_i,
    input  wire logic             eng_start_i,
    input  wire logic             eng_wr_i,
    input  wire ucp_pkg::ucp_byte_t eng_data_i,
    input  wire logic             ref_is_48m_i,
    input  wire logic             pll_bypass_select_i,
    output logic                  pll_bypass_o,
    output logic [2:0]            pll_mult_o
);
    import ucp_pkg::*;

    typedef struct packed {
        logic [1:0]             cs_n_s;
        logic [1:0]             rd_n_s;
        logic [1:0]             wr_n_s;
        logic [1:0]             sel_s;
        logic [1:0]             dack_n_s;
        logic [1:0]             byp_s;
        logic [1:0][7:0]        din_s;
        logic                   wr_act;
        logic                   rd_act;
        logic                   cyc_dma;
        logic                   cyc_data;
        ucp_byte_t              wr_lat;
        ucp_byte_t              ptr;
        ucp_byte_t              stat;
        ucp_byte_t              dma_cnt;
        ucp_byte_t              eng_off;
        logic [255:0][7:0]      mem;
        ucp_byte_t              dout;
        logic                   oe_n;
        logic                   irq;
        logic                   drq_n;
        logic                   byp;
        logic [2:0]             mult;
    } ucp_dev_s;

    ucp_dev_s st;
    ucp_dev_s next_st;

    logic      cs_on;
    logic      dma_on;
    logic      wr_now;
    logic      rd_now;
    ucp_byte_t reg_top;
    ucp_byte_t rd_val;
    ucp_byte_t eng_addr;

    always_comb
    begin
        next_st = st;
        // -----------------------------------------------------------------
        // Pin synchronisers
        // -----------------------------------------------------------------
        next_st.cs_n_s   = {st.cs_n_s[0], bus.chip_select_n};
        next_st.rd_n_s   = {st.rd_n_s[0], bus.read_strobe_n};
        next_st.wr_n_s   = {st.wr_n_s[0], bus.write_strobe_n};
        next_st.sel_s    = {st.sel_s[0], bus.addr_select_line};
        next_st.dack_n_s = {st.dack_n_s[0], bus.dma_ack_n};
        next_st.byp_s    = {st.byp_s[0], pll_bypass_select_i};
        next_st.din_s    = {st.din_s[0], bus.data_bus};

        reg_top = periph_mode_i ? `UCP_PERIPH_REG_TOP : `UCP_HOST_REG_TOP;   // RULE9 RULE10
        cs_on   = !st.cs_n_s[1];                                             // RULE3
        dma_on  = periph_mode_i && !st.dack_n_s[1];                          // RULE4
        wr_now  = !st.wr_n_s[1] && (cs_on || dma_on);
        rd_now  = !st.rd_n_s[1] && (cs_on || dma_on);
        next_st.wr_act = wr_now;
        next_st.rd_act = rd_now;

        // -----------------------------------------------------------------
        // Cycle tracking; write data follows the bus while the write strobe is low in a selected or acknowledged cycle
        // -----------------------------------------------------------------
        if ((wr_now && !st.wr_act) || (rd_now && !st.rd_act))
        begin
            next_st.cyc_dma = dma_on && !cs_on;
            next_st.cyc_data = st.sel_s[1];
        end
        if (wr_now)
        begin
            next_st.wr_lat = st.din_s[1];
        end

        // -----------------------------------------------------------------
        // Engine side writes into the configured buffer window
        // -----------------------------------------------------------------
        eng_addr = st.mem[`UCP_BASE_ADDR_REG] + st.eng_off;
        if (eng_start_i)
        begin
            next_st.eng_off = 8'h00;
        end
        else if (eng_wr_i && (st.eng_off < st.mem[`UCP_BASE_LEN_REG])
                 && (eng_addr >= reg_top))                                   // RULE13 RULE9 RULE10
        begin
            next_st.mem[eng_addr] = eng_data_i;                              // RULE13
            next_st.eng_off       = st.eng_off + 8'h01;
        end

        // -----------------------------------------------------------------
        // Commit on the first of strobe or select going inactive
        // -----------------------------------------------------------------
        if (st.wr_act && !wr_now)                                            // RULE2
        begin
            if (!st.cyc_dma && !st.cyc_data)
            begin
                next_st.ptr = st.wr_lat;                                     // RULE1 RULE12
            end
            else
            begin
                if (st.ptr == `UCP_INT_STAT_REG)
                begin
                    next_st.stat = st.stat & ~st.wr_lat;                     // RULE8
                end
                else if (periph_mode_i && (st.ptr == `UCP_DMA_CNT_REG) && !st.cyc_dma)
                begin
                    next_st.dma_cnt = st.wr_lat;                             // RULE6
                end
                else
                begin
                    next_st.mem[st.ptr] = st.wr_lat;                         // RULE1
                end
                next_st.ptr = st.ptr + 8'h01;                                // RULE11
                if (st.cyc_dma && (st.dma_cnt != 8'h00))
                begin
                    next_st.dma_cnt = st.dma_cnt - 8'h01;                    // RULE6
                end
            end
        end
        if (st.rd_act && !rd_now && (st.cyc_dma || st.cyc_data))             // RULE2
        begin
            next_st.ptr = st.ptr + 8'h01;                                    // RULE11
            if (st.cyc_dma && (st.dma_cnt != 8'h00))
            begin
                next_st.dma_cnt = st.dma_cnt - 8'h01;                        // RULE6
            end
        end

        // Events set after the clear so a coincident event is kept
        next_st.stat = next_st.stat | usb_event_i;                           // RULE8
        next_st.irq  = |(next_st.stat & st.mem[`UCP_INT_EN_REG]);            // RULE7

        // -----------------------------------------------------------------
        // Read path and pin drivers
        // -----------------------------------------------------------------
        if (st.ptr == `UCP_INT_STAT_REG)
        begin
            rd_val = st.stat;                                                // RULE8
        end
        else if (periph_mode_i && (st.ptr == `UCP_DMA_CNT_REG))
        begin
            rd_val = st.dma_cnt;
        end
        else
        begin
            rd_val = st.mem[st.ptr];
        end
        next_st.dout  = rd_val;
        next_st.oe_n  = !rd_now;                                             // RULE16 RULE3
        // Request stays low in peripheral mode until the block count runs out
        next_st.drq_n = !(periph_mode_i && (next_st.dma_cnt != 8'h00));      // RULE4 RULE5 RULE6

        next_st.byp  = !st.byp_s[1];                                         // RULE15
        next_st.mult = (next_st.byp || ref_is_48m_i) ? `UCP_MULT_DIRECT
                                                     : `UCP_MULT_12M;        // RULE14
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st         <= '0;
            st.cs_n_s  <= 2'h3;
            st.rd_n_s  <= 2'h3;
            st.wr_n_s  <= 2'h3;
            st.dack_n_s <= 2'h3;
            st.byp_s   <= 2'h3;
            st.oe_n    <= 1'b1;
            st.drq_n   <= 1'b1;
            st.mult    <= `UCP_MULT_DIRECT;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus.dev_data      = st.dout;
    assign bus.dev_data_oe_n = st.oe_n;
    assign bus.irq_out       = st.irq;
    assign bus.dma_request_n = st.drq_n;
    assign pll_bypass_o      = st.byp;
    assign pll_mult_o        = st.mult;

endmodule : ucp_dev

// ===== hdl/ucp_host.sv
// Bus master end of the processor port: turns user commands into pin cycles
`timescale 1ns/10ps
`include "ucp_defines.svh"

module ucp_host (
    input  wire logic               clock_i,
    input  wire logic               srst_i,
    ucp_if.host                     bus,
    input  wire logic               cmd_valid_i,
    input  wire ucp_pkg::ucp_cmd_e  cmd_kind_i,
    input  wire ucp_pkg::ucp_byte_t cmd_data_i,
    output logic                    cmd_ready_o,
    output logic                    rsp_valid_o,
    output ucp_pkg::ucp_byte_t      rsp_data_o,
    output logic                    drq_o,
    output logic                    irq_o
);
    import ucp_pkg::*;

    typedef struct packed {
        ucp_host_state_e state;
        logic [3:0]      cnt;
        logic            is_rd;
        logic            cs_n;
        logic            rd_n;
        logic            wr_n;
        logic            asel;
        logic            dack_n;
        ucp_byte_t       dout;
        logic            oe_n;
        logic            ready;
        logic            rsp_valid;
        ucp_byte_t       rsp_data;
        logic [1:0]      drq_s;
        logic [1:0]      irq_s;
        logic [1:0][7:0] din_s;
        logic            drq;
        logic            irq;
    } ucp_host_s;

    ucp_host_s st;
    ucp_host_s next_st;

    always_comb
    begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        next_st.drq_s     = {st.drq_s[0], !bus.dma_request_n};
        next_st.irq_s     = {st.irq_s[0], bus.irq_out};
        next_st.din_s     = {st.din_s[0], bus.data_bus};
        next_st.drq       = st.drq_s[1];
        next_st.irq       = st.irq_s[1];
        case (st.state)
            UCP_ST_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    next_st.is_rd  = (cmd_kind_i == UCP_CMD_DATA_RD)
                                     || (cmd_kind_i == UCP_CMD_DMA_RD);
                    next_st.asel   = (cmd_kind_i != UCP_CMD_ADDR_WR);        // RULE1
                    next_st.dack_n = !((cmd_kind_i == UCP_CMD_DMA_WR)
                                       || (cmd_kind_i == UCP_CMD_DMA_RD));   // RULE5
                    next_st.cs_n   = !next_st.dack_n;
                    next_st.rd_n   = !next_st.is_rd;
                    next_st.wr_n   = next_st.is_rd;
                    next_st.dout   = cmd_data_i;
                    next_st.oe_n   = next_st.is_rd;
                    next_st.ready  = 1'b0;
                    next_st.cnt    = 4'(`UCP_STROBE_CYC - 1);
                    next_st.state  = UCP_ST_STROBE;
                end
            end
            UCP_ST_STROBE:
            begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h0)
                begin
                    // Strobe rises first so data and select hold past the cycle end
                    next_st.rd_n = 1'b1;
                    next_st.wr_n = 1'b1;
                    if (st.is_rd)
                    begin
                        next_st.rsp_valid = 1'b1;
                        next_st.rsp_data  = st.din_s[1];
                    end
                    next_st.cnt   = 4'(`UCP_GAP_CYC - 1);
                    next_st.state = UCP_ST_GAP;
                end
            end
            UCP_ST_GAP:
            begin
                next_st.cs_n   = 1'b1;
                next_st.dack_n = 1'b1;
                next_st.oe_n   = 1'b1;
                next_st.cnt    = st.cnt - 4'h1;
                if (st.cnt == 4'h0)
                begin
                    next_st.ready = 1'b1;
                    next_st.state = UCP_ST_IDLE;
                end
            end
            default:
            begin
                next_st.state = UCP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st        <= '0;
            st.state  <= UCP_ST_IDLE;
            st.cs_n   <= 1'b1;
            st.rd_n   <= 1'b1;
            st.wr_n   <= 1'b1;
            st.dack_n <= 1'b1;
            st.oe_n   <= 1'b1;
            st.ready  <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus.chip_select_n    = st.cs_n;
    assign bus.read_strobe_n    = st.rd_n;
    assign bus.write_strobe_n   = st.wr_n;
    assign bus.addr_select_line = st.asel;
    assign bus.dma_ack_n        = st.dack_n;
    assign bus.host_data        = st.dout;
    assign bus.host_data_oe_n   = st.oe_n;
    assign cmd_ready_o          = st.ready;
    assign rsp_valid_o          = st.rsp_valid;
    assign rsp_data_o           = st.rsp_data;
    assign drq_o                = st.drq;
    assign irq_o                = st.irq;

endmodule : ucp_host

// ===== verification/ucp_checker.sv
// Pin-level checks on the port between bus master and controller
`timescale 1ns/10ps
module ucp_checker (
    input wire logic               clock_i,
    input wire logic               srst_i,
    input wire logic               chip_select_n,
    input wire logic               read_strobe_n,
    input wire logic               write_strobe_n,
    input wire logic               addr_select_line,
    input wire logic               irq_out,
    input wire logic               host_data_oe_n,
    input wire logic               dev_data_oe_n,
    input wire ucp_pkg::ucp_byte_t data_bus
);
    import ucp_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // ----------------------------------------
    // Cycles since the last write strobe
    // ----------------------------------------
    logic [4:0] since_wr;
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !write_strobe_n)
            since_wr <= 5'h00;
        else if (since_wr != 5'h1f)
            since_wr <= since_wr + 5'h01;
    end

    sequence wr_start_s;
        $fell(write_strobe_n);
    endsequence
    sequence wr_hold_s;
        (!write_strobe_n)[*7] ##1 write_strobe_n;
    endsequence
    sequence in_write_s;
        !write_strobe_n && $past(!write_strobe_n);
    endsequence

    wr_width_a: assert property (wr_start_s |-> ##1 wr_hold_s)
        else $error("write strobe width wrong");
    addr_stable_a: assert property (in_write_s |-> $stable(addr_select_line))
        else $error("address select moved in a write");
    data_stable_a: assert property (in_write_s |-> $stable(data_bus))
        else $error("data moved in a write");
    strobe_excl_a: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    no_contention_a: assert property (!(!host_data_oe_n && !dev_data_oe_n))
        else $error("both ends drive the bus");
    oe_prompt_a: assert property ($fell(read_strobe_n) && !chip_select_n
        |-> ##[1:4] !dev_data_oe_n) else $error("device did not drive read data");
    oe_after_read_a: assert property (!dev_data_oe_n |-> $past(!read_strobe_n, 2)
        || $past(!read_strobe_n, 3)) else $error("device drives without read");
    cs_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n[*5])
        else $error("select gap too short");
    irq_clear_a: assert property ($fell(irq_out) |-> since_wr <= 5'h08)
        else $error("interrupt dropped without a write");
endmodule : ucp_checker

// ===== verification/usb_ctrl_cpu_port_buffer_bench.sv
// Bench joining both ends of the processor port through one interface
`timescale 1ns/10ps
`include "ucp_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module usb_ctrl_cpu_port_buffer_bench;
    import ucp_pkg::*;
    typedef struct packed {ucp_cmd_e kind; ucp_byte_t data; ucp_byte_t exp;} ucp_row_s;

    logic      clock_i = 1'b0;
    logic      srst_i = 1'b1;
    logic      cmd_valid_i = 1'b0;
    ucp_cmd_e  cmd_kind_i = UCP_CMD_ADDR_WR;
    ucp_byte_t cmd_data_i = 8'h00;
    logic      periph_mode_i = 1'b0;
    logic [7:0] usb_event_i = 8'h00;
    logic      eng_start_i = 1'b0;
    logic      eng_wr_i = 1'b0;
    ucp_byte_t eng_data_i = 8'h00;
    logic      ref_is_48m_i = 1'b1;
    logic      pll_bypass_select_i = 1'b1;
    logic      cmd_ready_o, rsp_valid_o, drq_o, irq_o, pll_bypass_o, wr_sel;
    logic [2:0] pll_mult_o;
    ucp_byte_t rsp_data_o, wr_data, rd_byte;
    int        miscompares = 0;
    int        checks = 0;
    localparam ucp_row_s ROWS [12] = '{
        '{UCP_CMD_ADDR_WR, 8'h10, 8'h00}, '{UCP_CMD_DATA_WR, 8'ha5, 8'h00},
        '{UCP_CMD_DATA_WR, 8'h3c, 8'h00}, '{UCP_CMD_ADDR_WR, 8'h10, 8'h00},
        '{UCP_CMD_DATA_RD, 8'h00, 8'ha5}, '{UCP_CMD_DATA_RD, 8'h00, 8'h3c},
        '{UCP_CMD_ADDR_WR, 8'hff, 8'h00}, '{UCP_CMD_DATA_WR, 8'h81, 8'h00},
        '{UCP_CMD_ADDR_WR, 8'h05, 8'h00}, '{UCP_CMD_DATA_WR, 8'h5a, 8'h00},
        '{UCP_CMD_ADDR_WR, 8'hff, 8'h00}, '{UCP_CMD_DATA_RD, 8'h00, 8'h81}};

    ucp_if bus_if ();
    ucp_host u_ucp_host (.clock_i(clock_i), .srst_i(srst_i), .bus(bus_if.host),
        .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_data_i(cmd_data_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .drq_o(drq_o), .irq_o(irq_o));
    ucp_dev u_ucp_dev (.clock_i(clock_i), .srst_i(srst_i), .bus(bus_if.dev),
        .periph_mode_i(periph_mode_i), .usb_event_i(usb_event_i), .eng_start_i(eng_start_i),
        .eng_wr_i(eng_wr_i), .eng_data_i(eng_data_i), .ref_is_48m_i(ref_is_48m_i),
        .pll_bypass_select_i(pll_bypass_select_i), .pll_bypass_o(pll_bypass_o),
        .pll_mult_o(pll_mult_o));
    ucp_checker u_chk (.clock_i(clock_i), .srst_i(srst_i),
        .chip_select_n(bus_if.chip_select_n), .read_strobe_n(bus_if.read_strobe_n),
        .write_strobe_n(bus_if.write_strobe_n), .addr_select_line(bus_if.addr_select_line),
        .irq_out(bus_if.irq_out), .host_data_oe_n(bus_if.host_data_oe_n),
        .dev_data_oe_n(bus_if.dev_data_oe_n), .data_bus(bus_if.data_bus));

    always #(`UCP_CLK_PERIOD_NS / 2) clock_i = ~clock_i;

    // Last chip-selected write cycle as seen on the wire
    always @(posedge clock_i)
    begin
        if (!bus_if.write_strobe_n && !bus_if.chip_select_n)
        begin
            wr_sel <= bus_if.addr_select_line;
            wr_data <= bus_if.data_bus;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick

    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clock_i);
        while (cmd_ready_o !== 1'b1 && n < 100)
        begin
            @(negedge clock_i);
            n++;
        end
        // A host that never comes back ready is a failure, not a silent pass
        if (n >= 100)
            miscompares++;
    endtask : wait_ready

    task automatic host_op(input ucp_cmd_e kind, input ucp_byte_t data);
        int n;
        wait_ready();
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_kind_i <= kind;
        cmd_data_i <= data;
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        while (kind inside {UCP_CMD_DATA_RD, UCP_CMD_DMA_RD} && rsp_valid_o !== 1'b1 && n < 40)
        begin
            @(negedge clock_i);
            n++;
        end
        if (kind inside {UCP_CMD_DATA_RD, UCP_CMD_DMA_RD})
            `CHK(rsp_valid_o, 1'b1);
        rd_byte = rsp_data_o;
        wait_ready();
        tick(4);
    endtask : host_op

    task automatic wr_loc(input ucp_byte_t addr, input ucp_byte_t data);
        host_op(UCP_CMD_ADDR_WR, addr);
        host_op(UCP_CMD_DATA_WR, data);
    endtask : wr_loc

    task automatic rd_loc(input ucp_byte_t addr);
        host_op(UCP_CMD_ADDR_WR, addr);
        host_op(UCP_CMD_DATA_RD, 8'h00);
    endtask : rd_loc

    task automatic pulse_events(input logic [7:0] ev);
        @(posedge clock_i);
        usb_event_i <= ev;
        @(posedge clock_i);
        usb_event_i <= 8'h00;
        tick(6);
    endtask : pulse_events

    task automatic eng_fill(input ucp_byte_t base, input ucp_byte_t len, input ucp_byte_t d);
        wr_loc(`UCP_BASE_ADDR_REG, base);
        wr_loc(`UCP_BASE_LEN_REG, len);
        @(posedge clock_i);
        eng_start_i <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock_i);
            eng_start_i <= 1'b0;
            eng_wr_i <= 1'b1;
            eng_data_i <= d + 8'(i);
        end
        @(posedge clock_i);
        eng_wr_i <= 1'b0;
    endtask : eng_fill

    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        complete_run();
    end

    initial
    begin
        // Two edges; the control pin synchronisers reset to their idle levels, the data ones to zero
        tick(2);
        srst_i <= 1'b0;
        tick(4);
        `CHK(irq_o, 1'b0);
        `CHK(drq_o, 1'b0);
        `CHK(pll_mult_o, `UCP_MULT_DIRECT);
        `CHK(pll_bypass_o, 1'b0);
        foreach (ROWS[i])
        begin
            host_op(ROWS[i].kind, ROWS[i].data);
            if (ROWS[i].kind == UCP_CMD_DATA_RD)
                `CHK(rd_byte, ROWS[i].exp)
            else
            begin
                `CHK(wr_sel, ROWS[i].kind == UCP_CMD_DATA_WR);
                `CHK(wr_data, ROWS[i].data);
            end
        end
        // Reset again mid-run: idle outputs and a cleared buffer
        srst_i <= 1'b1;
        tick(2);
        srst_i <= 1'b0;
        tick(4);
        `CHK(cmd_ready_o, 1'b1);
        `CHK(irq_o, 1'b0);
        `CHK(drq_o, 1'b0);
        `CHK(pll_bypass_o, 1'b0);
        `CHK(pll_mult_o, `UCP_MULT_DIRECT);
        rd_loc(8'h10);
        `CHK(rd_byte, 8'h00);
        ref_is_48m_i <= 1'b0;
        tick(6);
        `CHK(pll_mult_o, `UCP_MULT_12M);
        pll_bypass_select_i <= 1'b0;
        tick(6);
        `CHK(pll_bypass_o, 1'b1);
        wr_loc(`UCP_INT_EN_REG, 8'h04);
        pulse_events(8'h02);
        `CHK(irq_o, 1'b0);
        pulse_events(8'h04);
        `CHK(irq_o, 1'b1);
        rd_loc(`UCP_INT_STAT_REG);
        `CHK(rd_byte, 8'h06);
        wr_loc(`UCP_INT_STAT_REG, 8'h04);
        `CHK(irq_o, 1'b0);
        rd_loc(`UCP_INT_STAT_REG);
        `CHK(rd_byte, 8'h02);
        // Length two, so the third engine byte must be dropped
        eng_fill(8'h20, 8'h02, 8'h11);
        rd_loc(8'h20);
        `CHK(rd_byte, 8'h11);
        host_op(UCP_CMD_DATA_RD, 8'h00);
        `CHK(rd_byte, 8'h12);
        host_op(UCP_CMD_DATA_RD, 8'h00);
        `CHK(rd_byte, 8'h00);
        periph_mode_i <= 1'b1;
        wr_loc(`UCP_DMA_CNT_REG, 8'h02);
        `CHK(drq_o, 1'b1);
        periph_mode_i <= 1'b0;
        tick(6);
        `CHK(drq_o, 1'b0);
        periph_mode_i <= 1'b1;
        tick(6);
        `CHK(drq_o, 1'b1);
        host_op(UCP_CMD_DMA_WR, 8'h77);
        host_op(UCP_CMD_DMA_WR, 8'h88);
        `CHK(drq_o, 1'b0);
        rd_loc(8'h3f);
        `CHK(rd_byte, 8'h77);
        host_op(UCP_CMD_DATA_RD, 8'h00);
        `CHK(rd_byte, 8'h88);
        wr_loc(`UCP_DMA_CNT_REG, 8'h01);
        host_op(UCP_CMD_DMA_RD, 8'h00);
        `CHK(rd_byte, 8'h77);
        eng_fill(8'h30, 8'h01, 8'h99);
        rd_loc(8'h30);
        `CHK(rd_byte, 8'h00);
        eng_fill(8'h40, 8'h01, 8'h5e);
        rd_loc(8'h40);
        `CHK(rd_byte, 8'h5e);
        complete_run();
    end
endmodule : usb_ctrl_cpu_port_buffer_bench
